// *** hdl/xpt_regs.svh ***
// Register map, field positions and source codes of the output crosspoint
`ifndef XPT_REGS_SVH
`define XPT_REGS_SVH
`define CTRL_BASE      8'h00
`define PEAK_BASE      8'h40
`define STATUS_OFS     8'h80
`define CTRL_SRC_LSB   0
`define CTRL_GAIN_LSB  8
`define CTRL_MUTE_BIT  16
`define CTRL_INV_BIT   17
`define STAT_BUSY_BIT  0
`define STAT_OVR_BIT   1
`define GAIN_MIN_DB    8'shb0
`define GAIN_MAX_DB    8'sh14
`define TONE_PEAK      24'h0ccccd
`define SRC_SILENCE    6'h00
`define SRC_EMB_BASE   6'h01
`define SRC_TONE_BASE  6'h11
`define SRC_TIMECODE   6'h21
`define SRC_DMX_L      6'h22
`define SRC_DMX_R      6'h23
`endif

// *** hdl/xpt_pkg.sv ***
// Types shared by the output crosspoint
package xpt_pkg;
  typedef logic signed [23:0] sample_t;
  typedef logic [5:0] src_sel_t;
  typedef struct packed {
    sample_t ch_a;
    sample_t ch_b;
  } aes_pair_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_CHAN = 4'b0010,
    S_TONE = 4'b0100,
    S_PUB  = 4'b1000
  } pass_state_t;
endpackage

// *** hdl/aes_output_audio_crosspoint.sv ***
// Sixteen-channel output audio crosspoint with gain, mute, invert and peak meters
// Notes on behaviour
// - Sixteen output channels, each with its own source, gain, mute and invert.
// - Sources: embedded inputs 1-16, tones 1-16, timecode audio, downmix L and R.
// - Sixteen sine tones at -20 dBFS, 100 Hz up to 16 kHz.
// - A silence choice gives zero; idle channels should use it.
// - Gain -80 to +20 dB in 1 dB steps, default 0 dB.
// - Each channel has mute, phase invert and a peak meter.
// - The peak meter follows the signal after the gain stage.
// - At 0 dB gain samples pass bit-exact.
// - Channels 2k-1 and 2k form AES pair k, eight pairs.
// - Only pairs one to four reach physical outputs.
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`include "xpt_regs.svh"
module aes_output_audio_crosspoint
  import xpt_pkg::*;
#(
  parameter int ADR_W = 8
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  sample_stb,
  input  wire sample_t [15:0]        embedded_input_channel,
  input  wire sample_t               timecode_audio_source,
  input  wire sample_t               downmix_left,
  input  wire sample_t               downmix_right,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [ADR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output aes_pair_t [3:0]            physical_output_channel,
  output logic                       pair_valid
);

  if (ADR_W != 8)
  begin : g_chk
    $error("ADR_W must be 8");
  end

  src_sel_t           src_ff   [16];
  logic signed [7:0]  gain_ff  [16];
  logic               mute_ff  [16];
  logic               inv_ff   [16];
  sample_t            out_ff   [16];
  logic [23:0]        peak_ff  [16];
  sample_t            tone_y1_ff [16];
  sample_t            tone_y2_ff [16];
  pass_state_t        st_ff;
  logic [3:0]         idx_ff;
  logic               overrun_ff;
  logic               ack_ff;
  logic [31:0]        rdat_ff;
  logic               pair_valid_ff;
  aes_pair_t [3:0]    pair_ff;

  // Resonator coefficient 2cos(w) in Q22 at a 48 kHz frame rate
  function automatic logic signed [24:0] tone_coef(input logic [3:0] k);
    case (k)
      4'h0: tone_coef = 25'sd8387889;
      4'h1: tone_coef = 25'sd8385734;
      4'h2: tone_coef = 25'sd8382141;
      4'h3: tone_coef = 25'sd8377112;
      4'h4: tone_coef = 25'sd8370647;
      4'h5: tone_coef = 25'sd8362749;
      4'h6: tone_coef = 25'sd8353418;
      4'h7: tone_coef = 25'sd8342655;
      4'h8: tone_coef = 25'sd8330462;
      4'h9: tone_coef = 25'sd8316843;
      4'ha: tone_coef = 25'sd8102758;
      4'hb: tone_coef = 25'sd7264748;
      4'hc: tone_coef = 25'sd5931642;
      4'hd: tone_coef = 25'sd4194304;
      4'he: tone_coef = 25'sd0;
      default: tone_coef = -25'sd4194304;
    endcase
  endfunction

  // Peak times sin(w): seeds the resonator so it starts at phase zero
  function automatic sample_t tone_seed(input logic [3:0] k);
    case (k)
      4'h0: tone_seed = 24'sd10980;
      4'h1: tone_seed = 24'sd21959;
      4'h2: tone_seed = 24'sd32934;
      4'h3: tone_seed = 24'sd43903;
      4'h4: tone_seed = 24'sd54864;
      4'h5: tone_seed = 24'sd65816;
      4'h6: tone_seed = 24'sd76757;
      4'h7: tone_seed = 24'sd87685;
      4'h8: tone_seed = 24'sd98599;
      4'h9: tone_seed = 24'sd109494;
      4'ha: tone_seed = 24'sd217115;
      4'hb: tone_seed = 24'sd419431;
      4'hc: tone_seed = 24'sd593164;
      4'hd: tone_seed = 24'sd726475;
      4'he: tone_seed = 24'(`TONE_PEAK);
      default: tone_seed = 24'sd726475;
    endcase
  endfunction

  // 10^(-r/20) in Q16 for the fractional decade
  function automatic logic [16:0] gain_mant(input logic [4:0] r);
    case (r)
      5'h00: gain_mant = 17'd65536;
      5'h01: gain_mant = 17'd58409;
      5'h02: gain_mant = 17'd52057;
      5'h03: gain_mant = 17'd46396;
      5'h04: gain_mant = 17'd41350;
      5'h05: gain_mant = 17'd36854;
      5'h06: gain_mant = 17'd32846;
      5'h07: gain_mant = 17'd29274;
      5'h08: gain_mant = 17'd26090;
      5'h09: gain_mant = 17'd23253;
      5'h0a: gain_mant = 17'd20724;
      5'h0b: gain_mant = 17'd18471;
      5'h0c: gain_mant = 17'd16462;
      5'h0d: gain_mant = 17'd14672;
      5'h0e: gain_mant = 17'd13076;
      5'h0f: gain_mant = 17'd11654;
      5'h10: gain_mant = 17'd10387;
      5'h11: gain_mant = 17'd9257;
      5'h12: gain_mant = 17'd8250;
      default: gain_mant = 17'd7353;
    endcase
  endfunction

  // 10^(1-k) in Q20 for whole decades
  function automatic logic signed [24:0] gain_dec(input logic [2:0] k);
    case (k)
      3'h0: gain_dec = 25'sd10485760;
      3'h1: gain_dec = 25'sd1048576;
      3'h2: gain_dec = 25'sd104858;
      3'h3: gain_dec = 25'sd10486;
      3'h4: gain_dec = 25'sd1049;
      default: gain_dec = 25'sd105;
    endcase
  endfunction

  // Source selection for the channel being processed
  src_sel_t    sel;
  logic [5:0]  sel_ofs;
  sample_t     src_smp;
  always_comb
  begin
    sel = src_ff[idx_ff];
    sel_ofs = sel - `SRC_EMB_BASE;
    src_smp = '0;
    if (sel >= `SRC_EMB_BASE && sel < `SRC_TONE_BASE)
      src_smp = embedded_input_channel[sel_ofs[3:0]];
    else if (sel >= `SRC_TONE_BASE && sel < `SRC_TIMECODE)
      src_smp = tone_y1_ff[sel_ofs[3:0]];
    else if (sel == `SRC_TIMECODE)
      src_smp = timecode_audio_source;
    else if (sel == `SRC_DMX_L)
      src_smp = downmix_left;
    else if (sel == `SRC_DMX_R)
      src_smp = downmix_right;
  end

  // Gain, invert, saturation and mute; two multiplies keep the table small
  logic signed [7:0]  g;
  logic [6:0]         att;
  logic signed [41:0] p1;
  logic signed [50:0] p2;
  logic signed [31:0] v;
  sample_t            nxt_smp;
  logic [23:0]        nxt_abs;
  always_comb
  begin
    g = gain_ff[idx_ff];
    att = 7'(8'sd20 - g);
    p1 = 42'(src_smp * $signed({1'b0, gain_mant(5'(att % 7'd20))}));
    p2 = 51'($signed(p1[41:16]) * gain_dec(3'(att / 7'd20)));
    if (g == 8'sh00)
      v = 32'(src_smp);
    else
      v = 32'($signed(p2[50:20]));
    if (inv_ff[idx_ff])
      v = -v;
    if (v > 32'sh007fffff)
      nxt_smp = 24'sh7fffff;
    else if (v < -32'sh00800000)
      nxt_smp = 24'sh800000;
    else
      nxt_smp = v[23:0];
    if (mute_ff[idx_ff])
      nxt_smp = '0;
    nxt_abs = nxt_smp[23] ? 24'(-nxt_smp) : 24'(nxt_smp);
  end

  // Tone resonator step; rounding may drift the level slowly over hours
  logic signed [48:0] tp;
  logic signed [26:0] tsum;
  always_comb
  begin
    tp = 49'(tone_y1_ff[idx_ff] * tone_coef(idx_ff));
    tsum = tp[48:22] - 27'(tone_y2_ff[idx_ff]);
  end

  // Frame pass: channels first, then tones, so every channel sees one tone phase
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_ff <= S_IDLE;
      idx_ff <= 4'h0;
    end
    else
    begin
      case (st_ff)
        S_IDLE:
          if (sample_stb)
            st_ff <= S_CHAN;
        S_CHAN:
        begin
          idx_ff <= idx_ff + 4'h1;
          if (idx_ff == 4'hf)
            st_ff <= S_TONE;
        end
        S_TONE:
        begin
          idx_ff <= idx_ff + 4'h1;
          if (idx_ff == 4'hf)
            st_ff <= S_PUB;
        end
        default:
          st_ff <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (!rst_n)
      begin
        tone_y1_ff[i] <= '0;
        tone_y2_ff[i] <= -tone_seed(4'(i));
      end
      else if (st_ff == S_TONE && idx_ff == 4'(i))
      begin
        tone_y1_ff[i] <= tsum[23:0];
        tone_y2_ff[i] <= tone_y1_ff[i];
      end
    end
  end

  // Bus decode
  logic        hit;
  logic        is_ctrl;
  logic        is_peak;
  logic        is_stat;
  logic [3:0]  bch;
  logic [31:0] nxt_rdat;
  logic signed [7:0] wgain;
  assign hit     = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign bch     = wb_adr_i[5:2];
  assign is_ctrl = wb_adr_i < `PEAK_BASE;
  assign is_peak = !is_ctrl && wb_adr_i < `STATUS_OFS;
  assign is_stat = wb_adr_i[7:2] == 6'(`STATUS_OFS >> 2);
  assign wgain   = $signed(wb_dat_i[`CTRL_GAIN_LSB +: 8]);

  always_comb
  begin
    nxt_rdat = '0;
    if (is_ctrl)
    begin
      nxt_rdat[`CTRL_SRC_LSB +: 6] = src_ff[bch];
      nxt_rdat[`CTRL_GAIN_LSB +: 8] = gain_ff[bch];
      nxt_rdat[`CTRL_MUTE_BIT] = mute_ff[bch];
      nxt_rdat[`CTRL_INV_BIT] = inv_ff[bch];
    end
    else if (is_peak)
      nxt_rdat[23:0] = peak_ff[bch];
    else if (is_stat)
    begin
      nxt_rdat[`STAT_BUSY_BIT] = st_ff != S_IDLE;
      nxt_rdat[`STAT_OVR_BIT] = overrun_ff;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= '0;
    end
    else
    begin
      ack_ff <= hit;
      rdat_ff <= hit ? nxt_rdat : 32'h0;
    end
  end

  // Channel controls; out-of-range gain is clamped on write
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (!rst_n)
      begin
        src_ff[i] <= `SRC_SILENCE;
        gain_ff[i] <= 8'sh00;
        mute_ff[i] <= 1'b0;
        inv_ff[i] <= 1'b0;
      end
      else if (hit && wb_we_i && is_ctrl && bch == 4'(i))
      begin
        if (wb_sel_i[0])
          src_ff[i] <= wb_dat_i[`CTRL_SRC_LSB +: 6];
        if (wb_sel_i[1])
          gain_ff[i] <= wgain < `GAIN_MIN_DB ? `GAIN_MIN_DB :
                        wgain > `GAIN_MAX_DB ? `GAIN_MAX_DB : wgain;
        if (wb_sel_i[2])
        begin
          mute_ff[i] <= wb_dat_i[`CTRL_MUTE_BIT];
          inv_ff[i] <= wb_dat_i[`CTRL_INV_BIT];
        end
      end
    end
  end

  // Outputs and meters; a meter read clears it, but a new sample still lands
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (!rst_n)
      begin
        out_ff[i] <= '0;
        peak_ff[i] <= '0;
      end
      else
      begin
        if (st_ff == S_CHAN && idx_ff == 4'(i))
          out_ff[i] <= nxt_smp;
        if (st_ff == S_CHAN && idx_ff == 4'(i))
          peak_ff[i] <= (hit && !wb_we_i && is_peak && bch == 4'(i)) || nxt_abs > peak_ff[i]
                        ? nxt_abs : peak_ff[i];
        else if (hit && !wb_we_i && is_peak && bch == 4'(i))
          peak_ff[i] <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      overrun_ff <= 1'b0;
    else if (sample_stb && st_ff != S_IDLE)
      overrun_ff <= 1'b1;
    else if (hit && wb_we_i && is_stat && wb_sel_i[0] && wb_dat_i[`STAT_OVR_BIT])
      overrun_ff <= 1'b0;
  end

  // Pairs 5 to 8 stay internal: no output path exists for them
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pair_ff <= '0;
      pair_valid_ff <= 1'b0;
    end
    else
    begin
      pair_valid_ff <= st_ff == S_PUB;
      if (st_ff == S_PUB)
        for (int k = 0; k < 4; k++)
        begin
          pair_ff[k].ch_a <= out_ff[2*k];
          pair_ff[k].ch_b <= out_ff[2*k+1];
        end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign physical_output_channel = pair_ff;
  assign pair_valid = pair_valid_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic [3:0] idx_q;
  logic [23:0] abs_q;
  always_ff @(posedge sys_clk)
  begin
    idx_q <= idx_ff;
    abs_q <= nxt_abs;
  end

  sequence chan_run_s;
    (st_ff == S_CHAN) [*8] ##1 (st_ff == S_CHAN) [*8];
  endsequence
  sequence tone_run_s;
    (st_ff == S_TONE) [*8] ##1 (st_ff == S_TONE) [*8];
  endsequence

  pass_order_a: assert property ((st_ff == S_IDLE && sample_stb) |=>
    chan_run_s ##1 tone_run_s ##1 st_ff == S_PUB ##1 pair_valid)
    else $error("frame pass out of order");
  mute_zero_a: assert property ((st_ff == S_CHAN && mute_ff[idx_ff]) |=>
    out_ff[idx_q] == 24'sh0)
    else $error("muted channel not zero");
  unity_exact_a: assert property ((st_ff == S_CHAN && !mute_ff[idx_ff] &&
    !inv_ff[idx_ff] && gain_ff[idx_ff] == 8'sh00) |=> out_ff[idx_q] == $past(src_smp))
    else $error("unity gain not bit exact");
  gain_range_a: assert property (gain_ff[bch] >= `GAIN_MIN_DB &&
    gain_ff[bch] <= `GAIN_MAX_DB)
    else $error("gain out of range");
  no_wrap_a: assert property ((st_ff == S_CHAN && !mute_ff[idx_ff] &&
    src_smp != 24'sh0 && gain_ff[idx_ff] >= 8'sh00 && !inv_ff[idx_ff]) |->
    nxt_smp[23] == src_smp[23])
    else $error("gain stage wrapped");
  peak_after_a: assert property ((st_ff == S_CHAN) |=> peak_ff[idx_q] >= abs_q)
    else $error("meter below output level");
  pair_map_a: assert property ((st_ff == S_PUB) |=>
    physical_output_channel[3].ch_b == out_ff[7] && physical_output_channel[0].ch_a == out_ff[0])
    else $error("pair mapping wrong");
  silence_a: assert property ((st_ff == S_CHAN && src_ff[idx_ff] == `SRC_SILENCE) |=>
    out_ff[idx_q] == 24'sh0)
    else $error("silence not silent");
  tone_level_a: assert property ((st_ff == S_TONE) |->
    $signed(tsum[23:0]) <= 24'sh0ce000 && $signed(tsum[23:0]) >= -24'sh0ce000)
    else $error("tone above level");
  wb_ack_a: assert property (hit |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not single");

endmodule

// *** tb/xpt_src_model.sv ***
// Upstream source model: de-embedder, timecode and downmix feeds
module xpt_src_model
  import xpt_pkg::*;
(
  output sample_t [15:0] embedded_input_channel,
  output sample_t        timecode_audio_source,
  output sample_t        downmix_left,
  output sample_t        downmix_right
);
  timeunit 1ns;
  timeprecision 1ns;

  // Distinct level per input so a misroute shows up as a wrong value
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      embedded_input_channel[i] = sample_t'((i + 1) << 12);
    end
  end

  // Downmix right sits near full scale and left at minus one eighth of it; a +20 dB boost clips both
  assign timecode_audio_source = 24'h123456;
  assign downmix_left          = 24'hf00000;
  assign downmix_right         = 24'h7f0000;
endmodule

// *** tb/aes_output_audio_crosspoint_tb.sv ***
// Self-checking bench for the output audio crosspoint
`include "xpt_regs.svh"
module aes_output_audio_crosspoint_tb
  import xpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(g, e) check_eq(32'(g), 32'(e))

  logic                  sys_clk;
  logic                  rst_n;
  logic                  sample_stb;
  sample_t [15:0]        embedded_input_channel;
  sample_t               timecode_audio_source;
  sample_t               downmix_left;
  sample_t               downmix_right;
  logic                  wb_cyc_i;
  logic                  wb_stb_i;
  logic                  wb_we_i;
  logic [7:0]            wb_adr_i;
  logic [3:0]            wb_sel_i;
  logic [31:0]           wb_dat_i;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  aes_pair_t [3:0]       physical_output_channel;
  logic                  pair_valid;
  int                    error_cnt = 0;
  int                    n_tests = 0;

  xpt_src_model src (.embedded_input_channel, .timecode_audio_source,
                     .downmix_left, .downmix_right);

  aes_output_audio_crosspoint #(.ADR_W(8)) dut (
    .sys_clk, .rst_n, .sample_stb, .embedded_input_channel, .timecode_audio_source,
    .downmix_left, .downmix_right, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .physical_output_channel, .pair_valid);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task check_eq(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Entered right after a rising edge; request held until ack is sampled
  task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
               output logic [31:0] q);
    int k;
    logic timed_out;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    timed_out = wb_ack_o !== 1'b1;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge sys_clk);
    if (timed_out)
    begin
      error_cnt++;
      summarize();
    end
  endtask

  task set_ch(input int ch, input logic [5:0] s, input logic [7:0] g,
              input logic mute, input logic inv);
    logic [31:0] q;
    wb_xfer(1'b1, 8'(4 * ch), {14'h0, inv, mute, g, 2'b00, s}, q);
  endtask

  task run_pass;
    int k;
    sample_stb <= 1'b1;
    @(posedge sys_clk);
    sample_stb <= 1'b0;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pair_valid !== 1'b1 && k < 60);
    if (pair_valid !== 1'b1)
    begin
      error_cnt++;
      summarize();
    end
  endtask

  function automatic sample_t outch(int n);
    return n[0] ? physical_output_channel[n / 2].ch_b : physical_output_channel[n / 2].ch_a;
  endfunction

  task t_defaults;
    logic [31:0] q;
    wb_xfer(1'b0, 8'h14, 32'h0, q);
    `CHK(q, 32'h0);
    run_pass();
    for (int n = 0; n < 8; n++)
      `CHK(outch(n), sample_t'(0));
  endtask

  // Reverse routing so a channel that follows its own index fails
  task t_route;
    for (int p = 0; p < 2; p++)
    begin
      for (int c = 0; c < 8; c++)
        set_ch(c, 6'(`SRC_EMB_BASE + 8 * p + 7 - c), 8'h00, 1'b0, 1'b0);
      run_pass();
      for (int n = 0; n < 8; n++)
        `CHK(outch(n), sample_t'((8 * p + 8 - n) << 12));
    end
  endtask

  task t_misc;
    logic [31:0] q;
    set_ch(0, `SRC_TIMECODE, 8'h00, 1'b0, 1'b0);
    set_ch(1, `SRC_DMX_L, 8'h00, 1'b0, 1'b0);
    set_ch(2, `SRC_DMX_R, 8'h00, 1'b0, 1'b0);
    set_ch(3, `SRC_EMB_BASE, 8'h00, 1'b0, 1'b1);
    set_ch(4, `SRC_DMX_R, 8'h14, 1'b1, 1'b1);
    set_ch(5, `SRC_DMX_L, 8'h14, 1'b0, 1'b0);
    set_ch(6, `SRC_DMX_R, 8'h14, 1'b0, 1'b0);
    set_ch(7, `SRC_SILENCE, 8'h14, 1'b0, 1'b0);
    set_ch(8, 6'(`SRC_EMB_BASE + 2), 8'h00, 1'b0, 1'b0);
    // Meter of channel 4 still holds its routing peak; read clears it
    wb_xfer(1'b0, 8'h50, 32'h0, q);
    `CHK(q[23:0], 24'h00c000);
    run_pass();
    `CHK(outch(0), sample_t'(24'h123456));
    `CHK(outch(1), sample_t'(24'hf00000));
    `CHK(outch(2), sample_t'(24'h7f0000));
    `CHK(outch(3), sample_t'(24'hfff000));
    `CHK(outch(4), sample_t'(0));
    `CHK(outch(5), sample_t'(24'h800000));
    `CHK(outch(6), sample_t'(24'h7fffff));
    `CHK(outch(7), sample_t'(0));
    wb_xfer(1'b0, 8'h58, 32'h0, q);
    `CHK(q[23:0], 24'h7fffff);
    wb_xfer(1'b0, 8'h48, 32'h0, q);
    `CHK(q[23:0], 24'h7f0000);
    wb_xfer(1'b0, 8'h50, 32'h0, q);
    `CHK(q[23:0], 24'h000000);
    wb_xfer(1'b0, 8'h60, 32'h0, q);
    `CHK(q[23:0], 24'h003000);
    wb_xfer(1'b0, 8'h60, 32'h0, q);
    `CHK(q[23:0], 24'h000000);
    set_ch(9, 6'h01, 8'h7f, 1'b0, 1'b0);
    wb_xfer(1'b0, 8'h24, 32'h0, q);
    `CHK(q[15:8], `GAIN_MAX_DB);
    set_ch(9, 6'h01, 8'h80, 1'b0, 1'b0);
    wb_xfer(1'b0, 8'h24, 32'h0, q);
    `CHK($signed(q[15:8]), `GAIN_MIN_DB);
    wb_xfer(1'b1, 8'h90, 32'hffffffff, q);
    wb_xfer(1'b0, 8'h90, 32'h0, q);
    `CHK(q, 32'h0);
  endtask

  // A tone must stay within its level and must not sit at zero
  task t_tone;
    int v;
    logic seen;
    seen = 1'b0;
    set_ch(0, 6'(`SRC_TONE_BASE + 15), 8'h00, 1'b0, 1'b0);
    set_ch(1, `SRC_TONE_BASE, 8'h00, 1'b0, 1'b0);
    for (int p = 0; p < 3; p++)
    begin
      run_pass();
      v = int'(outch(0));
      v = (v < 0) ? -v : v;
      `CHK(v <= int'(`TONE_PEAK), 1'b1);
      seen = seen | (v != 0);
    end
    `CHK(seen, 1'b1);
  endtask

  initial
  begin
    rst_n      = 1'b0;
    sample_stb = 1'b0;
    wb_cyc_i   = 1'b0;
    wb_stb_i   = 1'b0;
    wb_we_i    = 1'b0;
    wb_adr_i   = 8'h00;
    wb_sel_i   = 4'h0;
    wb_dat_i   = 32'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_defaults();
    t_route();
    t_misc();
    t_tone();
    summarize();
  end
endmodule
